// file: ffh_pkg.sv
// package for the fpu-to-cpu forwarding hazard model
package ffh_pkg;
  localparam int FREG_W = 3;
  localparam int DATA_W = 32;
  // floating op classes
  typedef enum logic [2:0] {
    FFH_OP_NONE,
    FFH_OP_FLOAT_MULTIPLY,
    FFH_OP_FLOAT_ADD,
    FFH_OP_FLOAT_SUBTRACT,
    FFH_OP_FLOAT_MULTIPLY_ACCUMULATE,
    FFH_OP_OTHER
  } ffh_fop_t;
  // move destinations
  typedef enum logic [1:0] {
    FFH_DST_FLOAT,
    FFH_DST_ACCUMULATOR,
    FFH_DST_PRODUCT,
    FFH_DST_MULTIPLICAND
  } ffh_dkind_t;
  typedef struct packed {
    logic valid;
    ffh_fop_t op;
    logic [FREG_W-1:0] dst;
    logic [DATA_W-1:0] result;
  } ffh_fissue_t;
  typedef struct packed {
    logic valid;
    logic [FREG_W-1:0] src;
    ffh_dkind_t dkind;
    logic aux;
    logic [2:0] aux_idx;
  } ffh_move_t;
  // stage offsets: issue enters e1; e3 is two stages later
  localparam int E3_STAGE = 2;
  localparam logic [DATA_W-1:0] RESET_VAL = 32'h0000_0000;
endpackage

// file: ffh_forward.sv
// fpu-to-cpu forwarding path with the e3-stall defect
// Function
// - two-cycle result forwarded in third execute phase
// - only multiply, add, subtract, mac are producers
// - hazard needs move source equal producer destination
// - hazard needs main-cpu move destination
// - float-to-float moves always get forwarded value
// - stall in third execute phase misses forward
// - no stall: move samples forward at second read
`timescale 1ns/1ps
`default_nettype none
module ffh_forward
  import ffh_pkg::*;
#(
  parameter int NREGS = 8
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic stall,
  input wire ffh_fissue_t fissue,
  input wire ffh_move_t move,
  output logic move_valid_q,
  output logic [DATA_W-1:0] move_data_q,
  output logic stale_read_q
);

  // elaboration check: the register index is three bits wide
  if (NREGS != 8)
  begin : g_nregs_check
    $error("ffh_forward: NREGS must be 8");
  end

  // the four two-cycle producer classes
  function automatic logic is_two_cycle(input ffh_fop_t op);
    unique case (op)
      FFH_OP_FLOAT_MULTIPLY,
      FFH_OP_FLOAT_ADD,
      FFH_OP_FLOAT_SUBTRACT,
      FFH_OP_FLOAT_MULTIPLY_ACCUMULATE:
        is_two_cycle = 1'b1;
      default:
        is_two_cycle = 1'b0;
    endcase
  endfunction

  // a move lands in a main-cpu register
  function automatic logic is_cpu_dest(input ffh_move_t mv);
    logic to_main;
    to_main = mv.aux;
    if (mv.dkind != FFH_DST_FLOAT)
    begin
      to_main = 1'b1;
    end
    is_cpu_dest = to_main;
  endfunction

  // a producer in a stage writes the given register
  function automatic logic feeds_reg(input ffh_fissue_t st,
    input logic [FREG_W-1:0] idx);
    feeds_reg = st.valid && is_two_cycle(st.op) && (st.dst == idx);
  endfunction

  ffh_fissue_t e1_q;
  ffh_fissue_t e2_q;
  ffh_fissue_t e3_q;
  logic [DATA_W-1:0] freg_q [NREGS];
  logic e3_stalled_q;
  logic advance;
  logic e3_producer;
  logic fwd_hit;
  logic to_cpu;
  logic miss;
  logic move_take;
  logic [DATA_W-1:0] fwd_value;
  logic [DATA_W-1:0] file_value;

  // the pipeline moves only when no stall is present
  assign advance = !stall;

  // first execute phase
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      e1_q <= '0;
    end
    else if (advance)
    begin
      e1_q <= fissue;
    end
  end

  // second execute phase
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      e2_q <= '0;
    end
    else if (advance)
    begin
      e2_q <= e1_q;
    end
  end

  // third execute phase: the forward is taken from here
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      e3_q <= '0;
    end
    else if (advance)
    begin
      e3_q <= e2_q;
    end
  end

  // producer sitting in the third execute phase
  assign e3_producer = e3_q.valid && is_two_cycle(e3_q.op);

  // remembers a stall seen while a producer sat in e3;
  // the flag clears again at the first edge with no stall
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      e3_stalled_q <= 1'b0;
    end
    else if (stall && e3_producer)
    begin
      e3_stalled_q <= 1'b1;
    end
    else if (advance)
    begin
      e3_stalled_q <= 1'b0;
    end
  end

  // register file write as e3 completes
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NREGS; i++)
      begin
        freg_q[i] <= RESET_VAL;
      end
    end
    else if (advance && e3_q.valid)
    begin
      freg_q[e3_q.dst] <= e3_q.result;
    end
  end

  // forward decode for the move in its second read phase;
  // float-to-float moves never take the miss path
  always_comb
  begin
    to_cpu = is_cpu_dest(move);
    fwd_hit = feeds_reg(e3_q, move.src);
    miss = fwd_hit && to_cpu && (stall || e3_stalled_q);
    move_take = move.valid && advance;
    fwd_value = e3_q.result;
    file_value = freg_q[move.src];
  end

  // completion pulse of a move
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      move_valid_q <= 1'b0;
    end
    else
    begin
      move_valid_q <= move_take;
    end
  end

  // pulse when the forward was missed
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      stale_read_q <= 1'b0;
    end
    else
    begin
      stale_read_q <= move.valid && miss;
    end
  end

  // read data: forwarded value or the register file
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      move_data_q <= RESET_VAL;
    end
    else if (move_take)
    begin
      if (fwd_hit && !miss)
      begin
        move_data_q <= fwd_value;
      end
      else
      begin
        move_data_q <= file_value;
      end
    end
  end
endmodule // ffh_forward
`default_nettype wire

// file: ffh_forward_sva.sv
// forwarding hazard checker
`timescale 1ns/1ps
`default_nettype none
module ffh_forward_sva
  import ffh_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic stall,
  input wire ffh_move_t move,
  input wire logic move_valid_q,
  input wire logic [DATA_W-1:0] move_data_q,
  input wire logic stale_read_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_move_done: assert property (move.valid && !stall |=> move_valid_q)
    else $error("move lost");
  a_answer_cause: assert property (move_valid_q |-> $past(move.valid))
    else $error("spurious move");
  a_stall_blocks: assert property (stall |=> !move_valid_q)
    else $error("move taken during stall");
  a_stale_cause: assert property (
    stale_read_q |-> $past(move.valid))
    else $error("stale pulse without move");
  a_stale_cpu: assert property (
    stale_read_q |-> $past(move.aux || (move.dkind != FFH_DST_FLOAT)))
    else $error("stale pulse on float move");
  a_stale_stall: assert property (
    stale_read_q |-> ($past(stall) || $past(stall, 2)))
    else $error("stale pulse without stall");
  a_data_holds: assert property (
    !move_valid_q |-> $stable(move_data_q))
    else $error("read data changed without move");
endmodule // ffh_forward_sva
bind ffh_forward ffh_forward_sva i_ffh_forward_sva (.clk_sys, .nrst,
  .stall, .move, .move_valid_q, .move_data_q, .stale_read_q);
`default_nettype wire

// file: ffh_cpu_model.sv
// cpu side: latches each completed move
`timescale 1ns/1ps
`default_nettype none
module ffh_cpu_model (
  input wire logic clk_sys,
  input wire logic move_valid_q,
  input wire logic [31:0] move_data_q,
  output logic [31:0] cpu_reg_q
);
  always_ff @(posedge clk_sys)
    if (move_valid_q)
      cpu_reg_q <= move_data_q;
endmodule // ffh_cpu_model
`default_nettype wire

// file: tb_ffh_forward.sv
// forwarding hazard testbench
`timescale 1ns/1ps
`default_nettype none
module tb_ffh_forward;
  import ffh_pkg::*;
  logic clk_sys = 0, nrst = 0, stall = 0, vq, sq;
  ffh_fissue_t fi = '0;
  ffh_move_t mv = '0;
  logic [31:0] dq, cq;
  int failures = 0, comparisons = 0, cyc = 0;
  ffh_forward i_ffh_forward (.clk_sys, .nrst, .stall, .fissue(fi),
    .move(mv), .move_valid_q(vq), .move_data_q(dq), .stale_read_q(sq));
  ffh_cpu_model i_ffh_cpu_model (.clk_sys, .move_valid_q(vq),
    .move_data_q(dq), .cpu_reg_q(cq));
  initial forever #5 clk_sys = ~clk_sys;
  task automatic tally_and_finish;
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys)
    if (cyc++ == 200)
    begin
      failures++;
      tally_and_finish;
    end
  task automatic cmp(input logic [33:0] g, e);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  // producer into reg 6, optional e3 stall, move from reg sr
  task automatic go(input ffh_fop_t op, input ffh_dkind_t dk,
    input logic stl, ax, es, input logic [2:0] sr,
    input logic [31:0] r, ed);
    @(posedge clk_sys) fi <= '{1'b1, op, 3'h6, r};
    @(posedge clk_sys) fi <= '0;
    @(posedge clk_sys);
    @(posedge clk_sys) stall <= stl;
    mv <= '{1'b1, sr, dk, ax, 3'h0};
    @(posedge clk_sys) stall <= 1'b0;
    if (stl) @(posedge clk_sys);
    mv <= '0;
    #1 cmp({vq, sq, dq}, {1'b1, es, ed});
    @(posedge clk_sys) #1 cmp(cq, ed);
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    go(FFH_OP_FLOAT_MULTIPLY, FFH_DST_ACCUMULATOR, 1, 0, 1, 3'h6,
      32'hA, 32'h0);
    go(FFH_OP_FLOAT_ADD, FFH_DST_PRODUCT, 0, 0, 0, 3'h6,
      32'hB, 32'hB);
    go(FFH_OP_FLOAT_SUBTRACT, FFH_DST_FLOAT, 1, 0, 0, 3'h6,
      32'hC, 32'hC);
    go(FFH_OP_FLOAT_MULTIPLY_ACCUMULATE, FFH_DST_FLOAT,
      0, 1, 0, 3'h6, 32'hD, 32'hD);
    go(FFH_OP_OTHER, FFH_DST_ACCUMULATOR, 1, 0, 0, 3'h6,
      32'hE, 32'hD);
    go(FFH_OP_FLOAT_MULTIPLY, FFH_DST_MULTIPLICAND, 1, 0, 0, 3'h5,
      32'hF, 32'h0);
    tally_and_finish;
  end
endmodule // tb_ffh_forward
`default_nettype wire
